// [hw/ircg_cfg.svh]
// constants for the ir carrier duty generator
// assumes apb with 32-bit data, one byte address per register, all unaligned except duty at e8
// Operation
// - duty compare value sets the high part length of each period
// - output goes low when counter equals duty compare value
// - counter overflow ends low part and starts next period
// - high time is compare minus reload, low time 256 minus compare
// - carrier on pin only with both enables; route only drives low
// - overflow at ff loads counter from reload register instead of wrapping to 00
// - new reload value waits in first buffer until next overflow
// - output held low while disabled or in power-down
`ifndef IRCG_CFG_SVH
`define IRCG_CFG_SVH
`define IRCG_OFS_MODE     8'hda
`define IRCG_OFS_COUNTER  8'hdb
`define IRCG_OFS_RELOAD   8'hcd
`define IRCG_OFS_DUTY     8'he8
`define IRCG_BIT_CARRIER  0
`define IRCG_BIT_ROUTE    1
`define IRCG_RST_BYTE     8'h00
`define IRCG_CNT_TOP      8'hff
`endif

// [hw/ircg_pkg.sv]
// types for the ir carrier duty generator
// assumes ircg_cfg.svh is available to the modules
package ircg_pkg;
   typedef struct packed {
      logic pin_route_enable;
      logic carrier_enable;
   } ircg_mode_t;

   typedef enum logic [1:0] {
      IRCG_IDLE = 2'b01,
      IRCG_RUN  = 2'b10
   } ircg_state_t;
endpackage

// [hw/ircg_pin_mux.sv]
// pin mux for the carrier output pin
// assumes registered inputs on pclk
`timescale 1ns/100ps
`default_nettype none
module ircg_pin_mux
(
   input  wire logic              carrier,     // running carrier level
   input  wire ircg_pkg::ircg_mode_t mode,     // enable bits
   input  wire logic              power_down,  // system power-down
   output logic                   pin_out,     // pin output level
   output logic                   pin_oe       // pin driven by carrier block
);
   always_comb
   begin
      pin_oe  = mode.pin_route_enable;
      pin_out = mode.pin_route_enable & mode.carrier_enable & ~power_down & carrier;
   end
endmodule // ircg_pin_mux
`default_nettype wire

// [hw/ircg_top.sv]
// ir carrier duty generator with apb register slave
// assumes pclk is the carrier clock; power_down is synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
`include "ircg_cfg.svh"
module ircg_top
(
   input  wire logic        pclk,          // clock, 125 MHz
   input  wire logic        presetn,       // async reset, active low
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb access phase
   input  wire logic        pwrite,        // apb direction
   input  wire logic [31:0] paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   input  wire logic        power_down,    // system power-down level
   output logic             carrier_output_pin,    // pin level
   output logic             carrier_output_pin_oe  // pin enable
);
   ircg_pkg::ircg_mode_t  mode_reg, mode_next;
   ircg_pkg::ircg_state_t state_reg, state_next;
   logic [7:0] carrier_counter_reg, carrier_counter_next;
   logic [7:0] reload_buf_reg, reload_buf_next;
   logic [7:0] period_reload_value_reg, period_reload_value_next;
   logic [7:0] duty_compare_value_reg, duty_compare_value_next;
   logic       carrier_reg, carrier_next;
   logic       prdata_en;
   logic [31:0] rdata;
   logic       wr, rd, hit, run, ovf;

   function automatic logic addr_is(input logic [31:0] a, input logic [7:0] ofs);
      addr_is = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
   endfunction

   assign wr  = psel & penable & pwrite;
   assign rd  = psel & penable & ~pwrite;
   assign run = mode_reg.carrier_enable & ~power_down;
   assign ovf = run & (carrier_counter_reg == `IRCG_CNT_TOP);
   assign hit = addr_is(paddr, `IRCG_OFS_MODE) | addr_is(paddr, `IRCG_OFS_COUNTER)
              | addr_is(paddr, `IRCG_OFS_RELOAD) | addr_is(paddr, `IRCG_OFS_DUTY);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   always_comb
   begin
      mode_next               = mode_reg;
      reload_buf_next         = reload_buf_reg;
      duty_compare_value_next = duty_compare_value_reg;
      period_reload_value_next = period_reload_value_reg;
      carrier_counter_next    = carrier_counter_reg;
      state_next              = state_reg;
      carrier_next            = carrier_reg;
      if (wr && addr_is(paddr, `IRCG_OFS_MODE))
      begin
         mode_next.carrier_enable   = pwdata[`IRCG_BIT_CARRIER];
         mode_next.pin_route_enable = pwdata[`IRCG_BIT_ROUTE];
      end
      if (wr && addr_is(paddr, `IRCG_OFS_RELOAD))
         reload_buf_next = pwdata[7:0];
      if (wr && addr_is(paddr, `IRCG_OFS_DUTY))
         duty_compare_value_next = pwdata[7:0];
      case (state_reg)
         ircg_pkg::IRCG_IDLE:
         begin
            carrier_next = 1'b0;
            // reload copies through while idle; first period counts up from the counter value as written
            period_reload_value_next = reload_buf_next;
            if (run)
            begin
               state_next = ircg_pkg::IRCG_RUN;
               carrier_next = 1'b1;
            end
         end
         ircg_pkg::IRCG_RUN:
         begin
            if (!run)
            begin
               state_next   = ircg_pkg::IRCG_IDLE;
               carrier_next = 1'b0;
            end
            else if (ovf)
            begin
               period_reload_value_next = reload_buf_reg;
               carrier_counter_next     = reload_buf_reg;
               carrier_next = 1'b1;
            end
            else
            begin
               carrier_counter_next = carrier_counter_reg + 8'h01;
               if (carrier_counter_next == duty_compare_value_reg)
                  carrier_next = 1'b0;
            end
         end
         default:
         begin
            state_next   = ircg_pkg::IRCG_IDLE;
            carrier_next = 1'b0;
         end
      endcase
      if (wr && addr_is(paddr, `IRCG_OFS_COUNTER))
         carrier_counter_next = pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_reg                <= '0;
         state_reg               <= ircg_pkg::IRCG_IDLE;
         carrier_counter_reg     <= `IRCG_RST_BYTE;
         reload_buf_reg          <= `IRCG_RST_BYTE;
         period_reload_value_reg <= `IRCG_RST_BYTE;
         duty_compare_value_reg  <= `IRCG_RST_BYTE;
         carrier_reg             <= 1'b0;
      end
      else
      begin
         mode_reg                <= mode_next;
         state_reg               <= state_next;
         carrier_counter_reg     <= carrier_counter_next;
         reload_buf_reg          <= reload_buf_next;
         period_reload_value_reg <= period_reload_value_next;
         duty_compare_value_reg  <= duty_compare_value_next;
         carrier_reg             <= carrier_next;
      end
   end

   // read mux: reload and duty are write-only, read as zero
   always_comb
   begin
      rdata = 32'h00000000;
      if (addr_is(paddr, `IRCG_OFS_MODE))
         rdata = {30'h00000000, mode_reg.pin_route_enable, mode_reg.carrier_enable};
      else if (addr_is(paddr, `IRCG_OFS_COUNTER))
         rdata = {24'h000000, carrier_counter_reg};
   end
   assign prdata_en = rd;
   assign prdata    = prdata_en ? rdata : 32'h00000000;

   ircg_pin_mux u_pin_mux
   (
      .carrier    (carrier_reg),
      .mode       (mode_reg),
      .power_down (power_down),
      .pin_out    (carrier_output_pin),
      .pin_oe     (carrier_output_pin_oe)
   );

   a_drop_at_match: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ircg_pkg::IRCG_RUN && run && !ovf && !wr
       && carrier_counter_reg + 8'h01 == duty_compare_value_reg)
      |=> !carrier_reg)
      else $error("carrier not low after compare match");
   a_reload_ovf: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ircg_pkg::IRCG_RUN && ovf && !wr)
      |=> carrier_counter_reg == $past(reload_buf_reg) && carrier_reg)
      else $error("counter not reloaded on overflow");
   a_buffer_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ircg_pkg::IRCG_RUN && run && !ovf)
      |=> $stable(period_reload_value_reg))
      else $error("reload changed without overflow");
   a_low_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      (!mode_reg.carrier_enable || power_down) |-> !carrier_output_pin)
      else $error("pin high while disabled");
   a_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
      carrier_output_pin |-> mode_reg.pin_route_enable && mode_reg.carrier_enable)
      else $error("pin high without both enables");
   a_start_high: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ircg_pkg::IRCG_IDLE && run) |=> carrier_reg)
      else $error("period did not start high");
   a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ircg_pkg::IRCG_RUN && run && !ovf && !wr)
      |=> carrier_counter_reg == $past(carrier_counter_reg) + 8'h01)
      else $error("counter did not advance");
   a_high_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (carrier_reg && state_reg == ircg_pkg::IRCG_RUN && run && !ovf && !wr
       && carrier_counter_reg + 8'h01 != duty_compare_value_reg) |=> carrier_reg)
      else $error("carrier dropped before compare");
   a_low_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!carrier_reg && state_reg == ircg_pkg::IRCG_RUN && run && !ovf) |=> !carrier_reg)
      else $error("carrier rose before overflow");
   a_stop_low: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ircg_pkg::IRCG_RUN && !run)
      |=> !carrier_reg && state_reg == ircg_pkg::IRCG_IDLE)
      else $error("carrier not stopped when disabled");
   a_route_oe: assert property (@(posedge pclk) disable iff (!presetn)
      carrier_output_pin_oe == mode_reg.pin_route_enable)
      else $error("pin enable differs from route bit");
   a_carrier_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg.pin_route_enable && mode_reg.carrier_enable && !power_down)
      |-> carrier_output_pin == carrier_reg)
      else $error("carrier not passed to pin");
   a_duty_store: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && addr_is(paddr, `IRCG_OFS_DUTY))
      |=> duty_compare_value_reg == $past(pwdata[7:0]))
      else $error("duty value not stored");
   a_reload_take: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ircg_pkg::IRCG_RUN && ovf)
      |=> period_reload_value_reg == $past(reload_buf_reg))
      else $error("active reload not taken at overflow");
   a_unmapped_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !hit)
      |=> $stable(reload_buf_reg) && $stable(duty_compare_value_reg) && $stable(mode_reg))
      else $error("unmapped write changed a register");
endmodule // ircg_top
`default_nettype wire

// [bench/ircg_emitter_model.sv]
// emitter driver model on the carrier output pin
// assumes pin level and pin enable from the block, sampled on pclk
`timescale 1ns/100ps
`default_nettype none
module ircg_emitter_model
(
   input  wire logic       pclk,      // block clock
   input  wire logic       pin,       // pin level
   input  wire logic       pin_oe,    // pin driven by block
   output logic      [8:0] high_len,  // last high run length
   output logic      [8:0] low_len    // last low run length
);
   logic       lvl;
   logic       last   = 1'b0;
   logic [8:0] run    = 9'h000;
   logic [8:0] high_q = 9'h000;
   logic [8:0] low_q  = 9'h000;
   // pull-down on emitter input when pin released
   assign lvl      = pin_oe ? pin : 1'b0;
   assign high_len = high_q;
   assign low_len  = low_q;
   // run lengths of each carrier level
   always @(posedge pclk)
   begin
      if (lvl === last)
         run <= run + 9'h001;
      else
      begin
         if (last === 1'b1)
            high_q <= run;
         else
            low_q <= run;
         run <= 9'h001;
      end
      last <= lvl;
   end
endmodule // ircg_emitter_model
`default_nettype wire

// [bench/ircg_top_bench.sv]
// bench for the ir carrier duty generator
// assumes ircg_cfg.svh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "ircg_cfg.svh"
module ircg_top_bench;
   logic        pclk, presetn, psel, penable, pwrite, power_down;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        pready, pslverr, pin, pin_oe, er;
   logic [8:0]  high_len, low_len;
   int          fail_count, n_tests;
   ircg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .power_down(power_down), .carrier_output_pin(pin),
      .carrier_output_pin_oe(pin_oe));
   ircg_emitter_model emitter (.pclk(pclk), .pin(pin), .pin_oe(pin_oe),
      .high_len(high_len), .low_len(low_len));
   always #4 pclk = ~pclk;
   task automatic report_and_stop;
      if (fail_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
         fail_count++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h000000, a};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_reset;
      apb(1'b0, `IRCG_OFS_MODE, 8'h00);
      chk("mode reset", 32'h00000000, rd);
      chk("mapped no error", 32'h00000000, {31'h0, er});
      apb(1'b0, `IRCG_OFS_COUNTER, 8'h00);
      chk("counter reset", 32'h00000000, rd);
      apb(1'b1, `IRCG_OFS_COUNTER, 8'h5a);
      apb(1'b0, `IRCG_OFS_COUNTER, 8'h00);
      chk("counter readback", 32'h0000005a, rd);
      apb(1'b0, `IRCG_OFS_RELOAD, 8'h00);
      chk("reload write only", 32'h00000000, rd);
      apb(1'b0, `IRCG_OFS_DUTY, 8'h00);
      chk("duty write only", 32'h00000000, rd);
      apb(1'b0, 8'h00, 8'h00);
      chk("unmapped error", 32'h00000001, {31'h0, er});
      apb(1'b1, 8'h00, 8'hff);
      chk("unmapped write error", 32'h00000001, {31'h0, er});
      chk("pin idle", 32'h00000000, {30'h0, pin_oe, pin});
   endtask
   task automatic t_carrier(input logic [7:0] rl, input logic [7:0] dt);
      apb(1'b1, `IRCG_OFS_COUNTER, rl);
      apb(1'b1, `IRCG_OFS_RELOAD, rl);
      apb(1'b1, `IRCG_OFS_DUTY, dt);
      apb(1'b1, `IRCG_OFS_MODE, 8'h01);
      apb(1'b1, `IRCG_OFS_MODE, 8'h03);
      apb(1'b0, `IRCG_OFS_MODE, 8'h00);
      chk("mode readback", 32'h00000003, rd);
      repeat (3 * (256 - rl) + 10) @(posedge pclk);
      chk("high time", {23'h0, 9'h000 + dt - rl}, {23'h0, high_len});
      chk("low time", {23'h0, 9'h100 - dt}, {23'h0, low_len});
   endtask
   task automatic t_modes;
      apb(1'b1, `IRCG_OFS_MODE, 8'h02);
      @(posedge pclk);
      chk("route only", 32'h00000002, {30'h0, pin_oe, pin});
      apb(1'b1, `IRCG_OFS_MODE, 8'h01);
      @(posedge pclk);
      chk("carrier only", 32'h00000000, {30'h0, pin_oe, pin});
   endtask
   task automatic t_power_down;
      int hi;
      hi = 0;
      apb(1'b1, `IRCG_OFS_MODE, 8'h03);
      power_down <= 1'b1;
      @(posedge pclk);
      repeat (300)
      begin
         @(posedge pclk);
         if (pin !== 1'b0) hi++;
      end
      chk("power down pin", 32'h00000000, hi);
      power_down <= 1'b0;
   endtask
   task automatic t_reload_buffer;
      apb(1'b1, `IRCG_OFS_RELOAD, 8'ha0);
      repeat (400) @(posedge pclk);
      chk("new high time", 32'h00000021, {23'h0, high_len});
      chk("new low time", 32'h0000003f, {23'h0, low_len});
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      report_and_stop();
   end
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, power_down} = 4'h0;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      fail_count = 0;
      n_tests = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_carrier(8'h97, 8'hba);
      t_modes();
      t_carrier(8'h83, 8'hc1);
      t_reload_buffer();
      t_power_down();
      t_carrier(8'h97, 8'hba);
      report_and_stop();
   end
endmodule // ircg_top_bench
`default_nettype wire
